// *** rtl/cgr_consts.svh ***
// register offsets, field positions, reset values and bus constants for the clock generator control bank
// Behaviour
// - spread_amp_ctrl bits 7:6 are read-only and return the latched spread strap as 00 low, 01 mid, 11 high.
// - spread_amp_ctrl bit 5 is a read/write override enable, reset 0, that hands spread choice to bits 4:3.
// - spread_amp_ctrl bits 4:3 reset to 00 and code 00 off, 01 -0.25%, 10 reserved, 11 -0.5% down-spread.
// - the software spread field has no effect on the spread output unless the override enable is one.
// - spread_amp_ctrl bits 1:0 are a read/write amplitude select, reset 10, codes 0.55V, 0.65V, 0.7V, 0.8V.
// - diff_edge_rate bit n picks slow (0) or fast (1) edges for differential output n, all resetting to 1.
// - ref_out_ctrl bits 7:6 are a read/write reference edge rate, reset 01, from slowest 00 to faster 11.
// - ref_out_ctrl bit 5, reset 0, keeps the reference output running in power down when set.
// - ref_out_ctrl bit 4, reset 1, enables the reference output and forces it low when clear.
// - rev_maker_id is read-only with revision code in bits 7:4 and maker code in bits 3:0.
// - part_type_id is read-only with family type in bits 7:6 and part code in bits 5:0.
// - readback_len bits 4:0 are a read/write block read count, reset 8, with bits 7:5 reading zero.
// - a block read after index write and repeated start returns the byte count first, then register bytes.
`ifndef CGR_CONSTS_SVH
`define CGR_CONSTS_SVH

`define CGR_OFF_SPREAD      8'h01
`define CGR_OFF_EDGE        8'h02
`define CGR_OFF_REF         8'h03
`define CGR_OFF_RSVD        8'h04
`define CGR_OFF_REV         8'h05
`define CGR_OFF_TYPE        8'h06
`define CGR_OFF_LEN         8'h07

`define CGR_SPR_OVR_BIT     5
`define CGR_SPR_SW_HI       4
`define CGR_SPR_SW_LO       3
`define CGR_SPR_RSVD_BIT    2
`define CGR_REF_WOL_BIT     5
`define CGR_REF_OE_BIT      4

`define CGR_RST_SW_SPREAD   2'h0
`define CGR_RST_AMP         2'h2
`define CGR_RST_EDGE        8'hFF
`define CGR_RST_REF_EDGE    2'h1
`define CGR_RST_WOL         1'h0
`define CGR_RST_REF_OE      1'h1
`define CGR_RST_LEN         5'h08
`define CGR_SPR_RSVD_VAL    1'h1
`define CGR_REF_RSVD_VAL    4'hF
`define CGR_STRAP_LOW       2'h0

`define CGR_ADDR_STRAP0     7'h68
`define CGR_ADDR_STRAP1     7'h6A
`define CGR_ACK_BIT         4'h8

`endif

// *** rtl/cgr_ctrl_regs.sv ***
// clock generator control register bank reached over the serial management bus
`timescale 1ns/100ps
`include "cgr_consts.svh"
module cgr_ctrl_regs #(
   parameter logic [3:0] SILICON_REV = 4'h3,  // arbitrary value
   parameter logic [3:0] MAKER_CODE  = 4'hA,  // arbitrary value
   parameter logic [1:0] PART_TYPE   = 2'h2,  // arbitrary value
   parameter logic [5:0] PART_CODE   = 6'h15  // arbitrary value
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       bus_addr_strap,
   input  wire logic [1:0] spread_strap_level,
   output logic [1:0]      spread_mode,
   output logic [1:0]      amp_sel,
   output logic [7:0]      diff_out_edge_sel,
   output logic [1:0]      ref_edge_sel,
   output logic            ref_wol_en,
   output logic            ref_out_en
);
   cgr_pkg::cgr_state_e state_reg;
   cgr_pkg::cgr_byte_t  index_reg;
   cgr_pkg::cgr_byte_t  wcount_reg;
   cgr_pkg::cgr_byte_t  tx_byte_reg;
   cgr_pkg::cgr_byte_t  rx_byte;
   logic                ack_reg;
   logic                tx_mode_reg;
   logic                strap_done_reg;
   logic [1:0]          spread_strap_readback;
   logic                addr_sel_reg;
   logic                spread_sw_override_en;
   logic [1:0]          spread_sw_sel;
   logic [1:0]          amp_reg;
   logic [7:0]          edge_reg;
   logic [1:0]          ref_edge_reg;
   logic                wol_reg;
   logic                ref_oe_reg;
   logic [4:0]          readback_len_bit;
   logic                start_p;
   logic                stop_p;
   logic                byte_done_p;
   logic                host_ack_p;
   logic                host_nack_p;
   logic                slot_end_p;

   // register read image, reserved bits at their defaults
   function automatic cgr_pkg::cgr_byte_t read_byte(input cgr_pkg::cgr_byte_t idx);
      cgr_pkg::cgr_byte_t v;
      case (idx)
         `CGR_OFF_SPREAD: v = {spread_strap_readback, spread_sw_override_en, spread_sw_sel,
                               `CGR_SPR_RSVD_VAL, amp_reg};
         `CGR_OFF_EDGE:   v = edge_reg;
         `CGR_OFF_REF:    v = {ref_edge_reg, wol_reg, ref_oe_reg, `CGR_REF_RSVD_VAL};
         `CGR_OFF_REV:    v = {SILICON_REV, MAKER_CODE};
         `CGR_OFF_TYPE:   v = {PART_TYPE, PART_CODE};
         `CGR_OFF_LEN:    v = {3'h0, readback_len_bit};
         default:         v = 8'h00;
      endcase
      return v;
   endfunction : read_byte

   cgr_smb_bit u_bit (
      .ref_clk     (ref_clk),
      .rst_b       (rst_b),
      .scl_in      (scl_in),
      .sda_in      (sda_in),
      .sda_out     (sda_out),
      .sda_oe      (sda_oe),
      .ack_drive   (ack_reg),
      .tx_mode     (tx_mode_reg),
      .tx_byte     (tx_byte_reg),
      .start_p     (start_p),
      .stop_p      (stop_p),
      .byte_done_p (byte_done_p),
      .host_ack_p  (host_ack_p),
      .host_nack_p (host_nack_p),
      .slot_end_p  (slot_end_p),
      .rx_byte     (rx_byte)
   );

   // address decode and write steering
   wire [6:0] my_addr   = addr_sel_reg ? `CGR_ADDR_STRAP1 : `CGR_ADDR_STRAP0;
   wire       addr_hit  = (rx_byte[7:1] == my_addr);
   wire       wr_strobe = byte_done_p & (state_reg == cgr_pkg::CGR_WDATA) & (wcount_reg != 8'h00);
   wire       wr_spread = wr_strobe & (index_reg == `CGR_OFF_SPREAD);
   wire       wr_edge   = wr_strobe & (index_reg == `CGR_OFF_EDGE);
   wire       wr_ref    = wr_strobe & (index_reg == `CGR_OFF_REF);
   wire       wr_len    = wr_strobe & (index_reg == `CGR_OFF_LEN);

   // strap capture once after reset release
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         strap_done_reg        <= 1'b0;
         spread_strap_readback <= `CGR_STRAP_LOW;
         addr_sel_reg          <= 1'b0;
      end
      else if (!strap_done_reg)
      begin
         strap_done_reg        <= 1'b1;
         spread_strap_readback <= spread_strap_level;
         addr_sel_reg          <= bus_addr_strap;
      end
   end

   // writable fields, other bits and bytes ignored
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         spread_sw_override_en <= 1'b0;
         spread_sw_sel         <= `CGR_RST_SW_SPREAD;
         amp_reg               <= `CGR_RST_AMP;
         edge_reg              <= `CGR_RST_EDGE;
         ref_edge_reg          <= `CGR_RST_REF_EDGE;
         wol_reg               <= `CGR_RST_WOL;
         ref_oe_reg            <= `CGR_RST_REF_OE;
         readback_len_bit      <= `CGR_RST_LEN;
      end
      else
      begin
         if (wr_spread)
         begin
            spread_sw_override_en <= rx_byte[`CGR_SPR_OVR_BIT];
            spread_sw_sel         <= rx_byte[`CGR_SPR_SW_HI:`CGR_SPR_SW_LO];
            amp_reg               <= rx_byte[1:0];
         end
         if (wr_edge)
            edge_reg <= rx_byte;
         if (wr_ref)
         begin
            ref_edge_reg <= rx_byte[7:6];
            wol_reg      <= rx_byte[`CGR_REF_WOL_BIT];
            ref_oe_reg   <= rx_byte[`CGR_REF_OE_BIT];
         end
         if (wr_len)
            readback_len_bit <= rx_byte[4:0];
      end
   end

   // transaction sequencing
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg   <= cgr_pkg::CGR_IDLE;
         index_reg   <= 8'h00;
         wcount_reg  <= 8'h00;
         tx_byte_reg <= 8'hFF;
         ack_reg     <= 1'b0;
         tx_mode_reg <= 1'b0;
      end
      else if (start_p)
      begin
         state_reg   <= cgr_pkg::CGR_ADDR;   // also a repeated start
         ack_reg     <= 1'b0;
         tx_mode_reg <= 1'b0;
      end
      else if (stop_p)
      begin
         state_reg   <= cgr_pkg::CGR_IDLE;
         ack_reg     <= 1'b0;
         tx_mode_reg <= 1'b0;
      end
      else if (byte_done_p)
      begin
         case (state_reg)
            cgr_pkg::CGR_ADDR:
            begin
               ack_reg <= addr_hit;
               if (!addr_hit)
                  state_reg <= cgr_pkg::CGR_IGNORE;
               else if (rx_byte[0])
               begin
                  state_reg   <= cgr_pkg::CGR_RDATA;
                  tx_byte_reg <= {3'h0, readback_len_bit};
               end
               else
                  state_reg <= cgr_pkg::CGR_INDEX;
            end
            cgr_pkg::CGR_INDEX:
            begin
               ack_reg   <= 1'b1;
               index_reg <= rx_byte;
               state_reg <= cgr_pkg::CGR_COUNT;
            end
            cgr_pkg::CGR_COUNT:
            begin
               ack_reg    <= 1'b1;
               wcount_reg <= rx_byte;
               state_reg  <= cgr_pkg::CGR_WDATA;
            end
            cgr_pkg::CGR_WDATA:
            begin
               ack_reg <= 1'b1;
               if (wcount_reg != 8'h00)
               begin
                  wcount_reg <= wcount_reg - 8'h01;
                  index_reg  <= index_reg + 8'h01;
               end
            end
            default:
               ack_reg <= 1'b0;
         endcase
      end
      else if (slot_end_p)
      begin
         ack_reg     <= 1'b0;
         tx_mode_reg <= (state_reg == cgr_pkg::CGR_RDATA);
      end
      else if (host_ack_p)
      begin
         tx_byte_reg <= read_byte(index_reg);
         index_reg   <= index_reg + 8'h01;
      end
      else if (host_nack_p)
      begin
         state_reg   <= cgr_pkg::CGR_IGNORE;
         tx_byte_reg <= 8'hFF;
      end
   end

   // control outputs toward the analog side
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         spread_mode       <= `CGR_STRAP_LOW;
         amp_sel           <= `CGR_RST_AMP;
         diff_out_edge_sel <= `CGR_RST_EDGE;
         ref_edge_sel      <= `CGR_RST_REF_EDGE;
         ref_wol_en        <= `CGR_RST_WOL;
         ref_out_en        <= `CGR_RST_REF_OE;
      end
      else
      begin
         spread_mode       <= spread_sw_override_en ? spread_sw_sel : spread_strap_readback;
         amp_sel           <= amp_reg;
         diff_out_edge_sel <= edge_reg;
         ref_edge_sel      <= ref_edge_reg;
         ref_wol_en        <= wol_reg;
         ref_out_en        <= ref_oe_reg;
      end
   end
endmodule : cgr_ctrl_regs

// *** rtl/cgr_pkg.sv ***
// types shared by the clock generator control bank
package cgr_pkg;
   typedef logic [7:0] cgr_byte_t;
   typedef enum logic [2:0] {
      CGR_IDLE,
      CGR_ADDR,
      CGR_INDEX,
      CGR_COUNT,
      CGR_WDATA,
      CGR_RDATA,
      CGR_IGNORE
   } cgr_state_e;
endpackage : cgr_pkg

// *** rtl/cgr_smb_bit.sv ***
// serial bus bit engine: start/stop detect, byte shifting, acknowledge slot handling
`timescale 1ns/100ps
`include "cgr_consts.svh"
module cgr_smb_bit (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic             scl_in,
   input  wire logic             sda_in,
   output logic                  sda_out,
   output logic                  sda_oe,
   input  wire logic             ack_drive,
   input  wire logic             tx_mode,
   input  wire cgr_pkg::cgr_byte_t tx_byte,
   output logic                  start_p,
   output logic                  stop_p,
   output logic                  byte_done_p,
   output logic                  host_ack_p,
   output logic                  host_nack_p,
   output logic                  slot_end_p,
   output cgr_pkg::cgr_byte_t    rx_byte
);
   logic       scl_q_reg;
   logic       sda_q_reg;
   logic       skip_reg;
   logic [3:0] cnt_reg;
   logic [7:0] rx_sh_reg;
   logic [7:0] tx_sh_reg;

   // line events seen against the previous sample
   wire scl_rise = scl_in & ~scl_q_reg;
   wire scl_fall = ~scl_in & scl_q_reg;
   wire is_ack   = (cnt_reg == `CGR_ACK_BIT);
   wire bit_fall = scl_fall & ~skip_reg;

   assign start_p     = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
   assign stop_p      = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
   assign byte_done_p = bit_fall & (cnt_reg == 4'h7);
   assign slot_end_p  = bit_fall & is_ack;
   assign host_ack_p  = scl_rise & is_ack & tx_mode & ~sda_in;
   assign host_nack_p = scl_rise & is_ack & tx_mode & sda_in;
   assign rx_byte     = rx_sh_reg;

   // open-drain drive: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe  = is_ack ? ack_drive : (tx_mode & ~tx_sh_reg[7]);

   // line sample history
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end
      else
      begin
         scl_q_reg <= scl_in;
         sda_q_reg <= sda_in;
      end
   end

   // bit counter and shifters
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         skip_reg  <= 1'b1;
         cnt_reg   <= 4'h0;
         rx_sh_reg <= 8'h00;
         tx_sh_reg <= 8'hFF;
      end
      else if (start_p || stop_p)
      begin
         skip_reg  <= 1'b1;        // first fall after start opens bit 0
         cnt_reg   <= 4'h0;
         tx_sh_reg <= 8'hFF;
      end
      else
      begin
         if (scl_rise && !is_ack)
            rx_sh_reg <= {rx_sh_reg[6:0], sda_in};
         if (scl_fall && skip_reg)
            skip_reg <= 1'b0;
         else if (bit_fall && is_ack)
         begin
            cnt_reg   <= 4'h0;
            tx_sh_reg <= tx_byte;  // next outgoing byte
         end
         else if (bit_fall)
         begin
            cnt_reg   <= cnt_reg + 4'h1;
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b1};
         end
      end
   end
endmodule : cgr_smb_bit

// *** verification/cgr_ctrl_regs_assertions.sv ***
// concurrent checks on the control bank ports
`timescale 1ns/100ps
module cgr_ctrl_regs_chk (
   input wire logic       ref_clk,
   input wire logic       rst_b,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic       bus_addr_strap,
   input wire logic [1:0] spread_strap_level,
   input wire logic [1:0] spread_mode,
   input wire logic [1:0] amp_sel,
   input wire logic [7:0] diff_out_edge_sel,
   input wire logic [1:0] ref_edge_sel,
   input wire logic       ref_wol_en,
   input wire logic       ref_out_en
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   // stored control outputs other than spread_mode in one vector
   wire [13:0] ctl_now = {amp_sel, diff_out_edge_sel, ref_edge_sel, ref_wol_en, ref_out_en};

   amp_reset_a: assert property ($rose(rst_b) |-> amp_sel == 2'h2)
      else $error("amplitude reset value wrong");
   edge_reset_a: assert property ($rose(rst_b) |-> diff_out_edge_sel == 8'hFF)
      else $error("edge rate reset value wrong");
   ref_edge_reset_a: assert property ($rose(rst_b) |-> ref_edge_sel == 2'h1)
      else $error("reference edge reset value wrong");
   wol_reset_a: assert property ($rose(rst_b) |-> !ref_wol_en)
      else $error("wake enable reset value wrong");
   ref_oe_reset_a: assert property ($rose(rst_b) |-> ref_out_en)
      else $error("reference enable reset value wrong");
   strap_follow_a: assert property ($rose(rst_b) |-> ##3 spread_mode == $past(spread_strap_level, 3))
      else $error("spread mode not from strap");
   write_in_ack_a: assert property ($changed(ctl_now) |-> sda_oe)
      else $error("control changed outside an acknowledged byte");
   data_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
      else $error("data line changed while bus clock high");

   cover property ($rose(sda_oe));
   cover property ($changed(amp_sel));
   cover property ($changed(spread_mode));
endmodule : cgr_ctrl_regs_chk

bind cgr_ctrl_regs cgr_ctrl_regs_chk i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .bus_addr_strap(bus_addr_strap), .spread_strap_level(spread_strap_level),
   .spread_mode(spread_mode), .amp_sel(amp_sel), .diff_out_edge_sel(diff_out_edge_sel),
   .ref_edge_sel(ref_edge_sel), .ref_wol_en(ref_wol_en), .ref_out_en(ref_out_en));

// *** verification/cgr_smb_host.sv ***
// serial management bus host model facing the control bank
`timescale 1ns/100ps
module cgr_smb_host (
   input  wire logic ref_clk,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda
);
   logic sda_drv = 1'b1;
   // open-drain data line with pull-up
   assign sda = sda_drv & ~sda_oe;
   initial scl = 1'b1;
   task automatic half();
      repeat (4) @(negedge ref_clk);
   endtask : half
   // one bit slot: drive b, sample the line mid-high
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      half();
      scl = 1'b1;
      repeat (2) @(negedge ref_clk);
      r = sda;
      repeat (2) @(negedge ref_clk);
      scl = 1'b0;
      half();
   endtask : bit_io
   task automatic start();
      sda_drv = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_drv = 1'b0;
      half();
      scl = 1'b0;
      half();
   endtask : start
   task automatic stop();
      sda_drv = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_drv = 1'b1;
      half();
   endtask : stop
   // byte out msb first, device acknowledge back
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask : wbyte
   // byte in, then ack or nack on the last
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask : rbyte
endmodule : cgr_smb_host

// *** verification/testbench.sv ***
// self-checking bench for the control register bank
`timescale 1ns/100ps
module testbench;
   logic       ref_clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       addr_strap = 1'b0;
   logic [1:0] strap = 2'h1;
   logic       scl, sda, sda_out, sda_oe, wol, oe;
   logic [1:0] smode, amp, redge;
   logic [7:0] dedge;
   logic [7:0] mdl [0:7];
   logic [7:0] wbuf [0:7];
   logic [31:0] seed = 32'hfeea;
   int         errors = 0;
   int         tests_run = 0;

   always #5 ref_clk = ~ref_clk;
   cgr_smb_host i_host (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   cgr_ctrl_regs #(.SILICON_REV(4'h6), .MAKER_CODE(4'h9), .PART_TYPE(2'h1), .PART_CODE(6'h2C)) i_dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .bus_addr_strap(addr_strap), .spread_strap_level(strap), .spread_mode(smode), .amp_sel(amp),
      .diff_out_edge_sel(dedge), .ref_edge_sel(redge), .ref_wol_en(wol), .ref_out_en(oe));

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   // writable bits of each byte
   function automatic logic [7:0] wmask(input int i);
      case (i)
         1: return 8'h3B;
         2: return 8'hFF;
         3: return 8'hF0;
         7: return 8'h1F;
         default: return 8'h00;
      endcase
   endfunction : wmask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic test_done();
      if (errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   // reset with given straps, model back to defaults
   task automatic do_rst(input logic [1:0] s, input logic a);
      @(negedge ref_clk);
      rst_b = 1'b0;
      strap = s;
      addr_strap = a;
      repeat (4) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge ref_clk);
      for (int i = 0; i < 8; i++) mdl[i] = 8'h00;
      mdl[1] = {s, 6'h06};
      mdl[2] = 8'hFF;
      mdl[3] = 8'h5F;
      mdl[5] = 8'h69;
      mdl[6] = 8'h6C;
      mdl[7] = 8'h08;
   endtask : do_rst
   // block write: index, count, then n bytes of wbuf
   task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] cnt, input int n, input logic ea);
      logic k;
      i_host.start();
      i_host.wbyte({a, 1'b0}, k);
      chk("addr ack", {7'h00, k}, {7'h00, ea});
      i_host.wbyte(idx, k);
      chk("index ack", {7'h00, k}, {7'h00, ea});
      i_host.wbyte(cnt, k);
      chk("count ack", {7'h00, k}, {7'h00, ea});
      for (int j = 0; j < n; j++)
      begin
         i_host.wbyte(wbuf[j], k);
         chk("data ack", {7'h00, k}, {7'h00, ea});
         if (ea && j < cnt && idx + j < 8)
            mdl[idx + j] = (mdl[idx + j] & ~wmask(idx + j)) | (wbuf[j] & wmask(idx + j));
      end
      i_host.stop();
   endtask : wr
   // block read: count byte first, then n register bytes
   task automatic rd(input logic [6:0] a, input logic [7:0] idx, input int n);
      logic k;
      logic [7:0] d;
      i_host.start();
      i_host.wbyte({a, 1'b0}, k);
      i_host.wbyte(idx, k);
      i_host.start();
      i_host.wbyte({a, 1'b1}, k);
      chk("read ack", {7'h00, k}, 8'h01);
      i_host.rbyte(1'b0, d);
      chk("count", d, mdl[7]);
      for (int j = 0; j < n; j++)
      begin
         i_host.rbyte(j == n - 1, d);
         chk("reg", d, (idx + j < 8) ? mdl[idx + j] : 8'h00);
      end
      i_host.stop();
   endtask : rd
   task automatic chk_out();
      chk("sda out", {7'h00, sda_out}, 8'h00);
      chk("amp", {6'h00, amp}, {6'h00, mdl[1][1:0]});
      chk("edge", dedge, mdl[2]);
      chk("ref", {4'h0, redge, wol, oe}, {4'h0, mdl[3][7:4]});
      chk("spread", {6'h00, smode}, {6'h00, mdl[1][5] ? mdl[1][4:3] : strap});
   endtask : chk_out

   // hang guard
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      errors++;
      test_done();
   end
   // main sequence
   initial
   begin
      do_rst(2'h1, 1'b0);
      rd(7'h68, 8'h00, 8);
      chk_out();
      // soft spread field set, override still off
      wbuf[0] = 8'h18;
      wr(7'h68, 8'h01, 8'h01, 1, 1'b1);
      chk_out();
      // random fills across all bytes, read-only ones too
      repeat (6)
      begin
         for (int j = 0; j < 8; j++) wbuf[j] = rnd();
         wr(7'h68, 8'h01, 8'h07, 7, 1'b1);
         chk_out();
         rd(7'h68, 8'h01, 7);
      end
      // byte past the count is dropped
      wbuf[0] = 8'h00;
      wbuf[1] = 8'h00;
      wr(7'h68, 8'h02, 8'h01, 2, 1'b1);
      rd(7'h68, 8'h02, 2);
      // reads running past the last byte return zero
      rd(7'h68, 8'h06, 4);
      // foreign address stays silent
      wbuf[0] = 8'h55;
      wr(7'h6A, 8'h02, 8'h01, 1, 1'b0);
      rd(7'h68, 8'h02, 1);
      // each strap level, alternate address
      for (int i = 0; i < 3; i++)
      begin
         do_rst((i == 0) ? 2'h0 : (i == 1) ? 2'h3 : 2'h1, 1'b1);
         chk_out();
         rd(7'h6A, 8'h01, 1);
         wr(7'h68, 8'h02, 8'h01, 1, 1'b0);
      end
      test_done();
   end
endmodule : testbench
